/* File: logic/lam_pkg.sv */
// shared constants and bus carrier types for the channel mask and receive info block
package lam_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;
    // register indices, byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_SUMMARY = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_MASK = 8'h07;
    localparam logic [ADDR_W-1:0] IDX_RXINFO = 8'h08;
    localparam logic [REG_W-1:0] MASK_RESET = 8'h00;
    localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
    // status bit positions
    localparam int unsigned ST_LOOP_UP = 7;
    localparam int unsigned ST_LOOP_DN = 6;
    localparam int unsigned ST_TXCLK_LOST = 5;
    localparam int unsigned ST_UNFR_ONES = 4;
    localparam int unsigned ST_CARRIER = 3;
    localparam int unsigned ST_CUR_LIMIT = 2;
    localparam int unsigned ST_OPEN_CKT = 1;
    localparam int unsigned ST_PRBS = 0;
    // latched status bits, the rest follow their condition live
    localparam logic [REG_W-1:0] ST_LATCHED = 8'hD8;
    // receive info bit positions
    localparam int unsigned RI_ZERO_RUN = 7;
    localparam int unsigned RI_SIXTEEN = 6;
    localparam int unsigned RI_CODEWORD = 5;
    localparam int unsigned RI_CARR_CLR = 4;
    localparam int unsigned RI_ONES_END = 3;
    localparam int unsigned RI_JIT_LIM = 2;
    localparam logic [REG_W-1:0] RI_USED = 8'hFC;
    // zero run thresholds and jitter margin
    localparam logic [4:0] ZRUN_SHORT = 5'h04;
    localparam logic [4:0] ZRUN_LONG = 5'h08;
    localparam logic [4:0] ZRUN_SIXTEEN = 5'h10;
    localparam logic [7:0] JIT_MARGIN = 8'h04;
    // transmit clock watchdog and channel count
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned TXCLK_IDLE_US = 5;
    localparam int unsigned TXCLK_IDLE_CYC = TXCLK_IDLE_US * CLK_MHZ;
    localparam int unsigned TXCNT_W = 11;
    localparam logic [TXCNT_W-1:0] TXCLK_LIMIT = TXCNT_W'(TXCLK_IDLE_CYC);
    localparam int unsigned NUM_CHAN = 4;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } lam_apb_req_t;

    typedef struct packed {
        logic prdata_dummy;
    } lam_unused_t;

    // one received symbol: mark present and bipolar violation
    typedef struct packed {
        logic mark;
        logic viol;
    } lam_sym_t;
endpackage

/* File: logic/lam_channel_regs.sv */
// one line channel: interrupt mask, status, receive event flags and channel summary
//
// What this block does
// R1: eight mask bits, one per status bit; 0 blocks, 1 allows interrupt
// R2: zero-run flag sets on 4 zeros (select 0) or 8 (select 1); read clears
// R3: sixteen-zero flag sets on 16 or more consecutive zeros; read clears
// R4: codeword flag sets on HDB3 word (select 0) or B8ZS word (select 1) even with decoding off; read clears
// R5: carrier-loss clear flag sets when carrier loss ends; held until read
// R6: unframed ones end flag sets when all-ones stops; held until read
// R7: jitter flag sets when FIFO is within 4 bits of limit; read clears
// R8: receive info bits 1 and 0 unassigned; software ignores them
// R9: summary register bit n reads 1 while channel n+1 interrupts
// R10: transmit clock lost after 5 us without transition
// R11: interrupt high while any status bit set with its mask bit 1
//
// The implementer's own choice: the APB slave port.
module lam_channel_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire lam_pkg::lam_apb_req_t apb_req,
    output logic [lam_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_bit_valid,
    input wire logic rx_pos,
    input wire logic rx_neg,
    input wire logic line_standard_select,
    input wire logic loop_up_code_seen,
    input wire logic loop_down_code_seen,
    input wire logic unframed_ones_rx,
    input wire logic carrier_loss,
    input wire logic tx_current_limit_hit,
    input wire logic tx_open_circuit,
    input wire logic prbs_pattern_found,
    input wire logic tx_clock_in,
    input wire logic [7:0] jitter_fifo_margin,
    input wire logic [lam_pkg::NUM_CHAN-1:1] other_chan_irq,
    output logic tx_clock_lost,
    output logic irq
);
    import lam_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx);
        hit = (addr == ADDR_W'({idx, 2'b00}));
    endfunction

    logic [REG_W-1:0] irq_mask_reg_r;
    logic [REG_W-1:0] status_flags_reg_r;
    logic [REG_W-1:0] rx_info_one_r;
    logic [REG_W-1:0] rx_info_one_nxt;
    logic [REG_W-1:0] status_view;
    logic [REG_W-1:0] rd_val;
    logic [4:0] zrun_r;
    logic [4:0] zrun_nxt;
    lam_sym_t [7:0] sym_hist_r;
    lam_sym_t sym_now;
    logic last_pol_r;
    logic carrier_d_r;
    logic ones_d_r;
    logic txclk_d_r;
    logic [TXCNT_W-1:0] txclk_cnt_r;
    logic tx_clock_lost_r;
    logic irq_r;
    logic pready_r;
    logic pslverr_r;
    logic [DATA_W-1:0] prdata_r;
    logic [REG_W-1:0] rd_taken_r;
    logic setup;
    logic done;
    logic wr_done;
    logic rd_rxinfo_done;
    logic mapped;
    logic hdb3_word;
    logic b8zs_word;
    logic [REG_W-1:0] ri_set;

    assign setup = apb_req.psel && !apb_req.penable;
    assign done = apb_req.psel && apb_req.penable && pready_r;
    assign wr_done = done && apb_req.pwrite;
    assign rd_rxinfo_done = done && !apb_req.pwrite && hit(apb_req.paddr, IDX_RXINFO);
    assign mapped = hit(apb_req.paddr, IDX_SUMMARY) || hit(apb_req.paddr, IDX_STATUS)
        || hit(apb_req.paddr, IDX_MASK) || hit(apb_req.paddr, IDX_RXINFO);

    // receive symbol decode: a mark with the same polarity as the last is a violation
    always_comb begin
        sym_now.mark = rx_pos ^ rx_neg;
        sym_now.viol = sym_now.mark && (rx_pos == last_pol_r);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_pol_r <= 1'b0;
            sym_hist_r <= '0;
        end else if (rx_bit_valid) begin
            if (sym_now.mark) begin
                last_pol_r <= rx_pos;
            end
            sym_hist_r <= {sym_hist_r[6:0], sym_now};
        end
    end

    // codeword match on the history including the newest symbol
    always_comb begin
        hdb3_word = rx_bit_valid && sym_now.viol && !sym_hist_r[0].mark && !sym_hist_r[1].mark;
        b8zs_word = rx_bit_valid && sym_now.mark && !sym_now.viol
            && sym_hist_r[0].viol && !sym_hist_r[1].mark
            && sym_hist_r[2].mark && !sym_hist_r[2].viol
            && sym_hist_r[3].viol && !sym_hist_r[4].mark
            && !sym_hist_r[5].mark && !sym_hist_r[6].mark;
    end

    // saturating zero-run counter, so long runs never wrap
    always_comb begin
        zrun_nxt = zrun_r;
        if (rx_bit_valid) begin
            if (sym_now.mark) begin
                zrun_nxt = 5'h00;
            end else if (zrun_r != ZRUN_SIXTEEN) begin
                zrun_nxt = zrun_r + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            zrun_r <= 5'h00;
        end else begin
            zrun_r <= zrun_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            carrier_d_r <= 1'b0;
            ones_d_r <= 1'b0;
        end else begin
            carrier_d_r <= carrier_loss;
            ones_d_r <= unframed_ones_rx;
        end
    end

    always_comb begin
        ri_set = REG_ZERO;
        ri_set[RI_ZERO_RUN] = line_standard_select ? (zrun_nxt >= ZRUN_LONG)
            : (zrun_nxt >= ZRUN_SHORT); // R2
        ri_set[RI_SIXTEEN] = (zrun_nxt == ZRUN_SIXTEEN); // R3
        ri_set[RI_CODEWORD] = line_standard_select ? b8zs_word : hdb3_word; // R4
        ri_set[RI_CARR_CLR] = carrier_d_r && !carrier_loss; // R5
        ri_set[RI_ONES_END] = ones_d_r && !unframed_ones_rx; // R6
        ri_set[RI_JIT_LIM] = (jitter_fifo_margin <= JIT_MARGIN); // R7
    end

    // only bits actually returned by the read are cleared; a new event wins
    always_comb begin
        rx_info_one_nxt = rx_info_one_r;
        if (rd_rxinfo_done) begin
            rx_info_one_nxt = rx_info_one_r & ~rd_taken_r;
        end
        rx_info_one_nxt = (rx_info_one_nxt | ri_set) & RI_USED; // R8
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_info_one_r <= REG_ZERO;
        end else begin
            rx_info_one_r <= rx_info_one_nxt;
        end
    end

    // transmit clock watchdog, counts cycles since the last level change
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txclk_d_r <= 1'b0;
            txclk_cnt_r <= '0;
            tx_clock_lost_r <= 1'b0;
        end else begin
            txclk_d_r <= tx_clock_in;
            if (tx_clock_in != txclk_d_r) begin
                txclk_cnt_r <= '0;
                tx_clock_lost_r <= 1'b0;
            end else if (txclk_cnt_r != TXCLK_LIMIT) begin
                txclk_cnt_r <= txclk_cnt_r + 1'b1;
            end else begin
                tx_clock_lost_r <= 1'b1; // R10
            end
        end
    end

    // latched status bits are write-one-to-clear with set winning
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_flags_reg_r <= REG_ZERO;
        end else begin
            status_flags_reg_r <= ((wr_done && hit(apb_req.paddr, IDX_STATUS))
                ? status_flags_reg_r & ~apb_req.pwdata[REG_W-1:0] : status_flags_reg_r)
                | ({loop_up_code_seen, loop_down_code_seen, 1'b0, unframed_ones_rx,
                    carrier_loss, 3'b000} & ST_LATCHED);
        end
    end

    always_comb begin
        status_view = status_flags_reg_r & ST_LATCHED;
        status_view[ST_TXCLK_LOST] = tx_clock_lost_r;
        status_view[ST_CUR_LIMIT] = tx_current_limit_hit;
        status_view[ST_OPEN_CKT] = tx_open_circuit;
        status_view[ST_PRBS] = prbs_pattern_found;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_mask_reg_r <= MASK_RESET;
        end else if (wr_done && hit(apb_req.paddr, IDX_MASK)) begin
            irq_mask_reg_r <= apb_req.pwdata[REG_W-1:0]; // R1
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_view & irq_mask_reg_r); // R11
        end
    end

    always_comb begin
        rd_val = REG_ZERO;
        if (hit(apb_req.paddr, IDX_SUMMARY)) begin
            rd_val[NUM_CHAN-1:0] = {other_chan_irq, irq_r}; // R9
        end else if (hit(apb_req.paddr, IDX_STATUS)) begin
            rd_val = status_view;
        end else if (hit(apb_req.paddr, IDX_MASK)) begin
            rd_val = irq_mask_reg_r;
        end else if (hit(apb_req.paddr, IDX_RXINFO)) begin
            rd_val = rx_info_one_r;
        end
    end

    // data is captured in setup so the access phase completes with no wait
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            rd_taken_r <= REG_ZERO;
        end else begin
            pready_r <= setup;
            if (setup) begin
                pslverr_r <= !mapped;
                prdata_r <= apb_req.pwrite ? '0 : DATA_W'(rd_val);
                rd_taken_r <= rd_val;
            end else if (done) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign tx_clock_lost = tx_clock_lost_r;

    property p_mask_write;
        @(posedge ref_clk) disable iff (rst)
        (wr_done && hit(apb_req.paddr, IDX_MASK)) |=> (irq_mask_reg_r == $past(apb_req.pwdata[7:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // R1

    property p_zero_run;
        @(posedge ref_clk) disable iff (rst)
        (rx_bit_valid && !sym_now.mark && !line_standard_select && zrun_r == 5'h03)
            |=> rx_info_one_r[RI_ZERO_RUN];
    endproperty
    a_zero_run: assert property (p_zero_run) else $error("zero run flag missed"); // R2

    property p_zero_run_long;
        @(posedge ref_clk) disable iff (rst)
        (rx_bit_valid && line_standard_select && zrun_r < 5'h07 && !rx_info_one_r[RI_ZERO_RUN]
            && !(rx_bit_valid && !sym_now.mark && zrun_r == 5'h07)) |=> !rx_info_one_r[RI_ZERO_RUN];
    endproperty
    a_zero_run_long: assert property (p_zero_run_long) else $error("zero run set early"); // R2

    property p_sixteen;
        @(posedge ref_clk) disable iff (rst)
        (rx_bit_valid && !sym_now.mark && zrun_r == 5'h0F) |=> rx_info_one_r[RI_SIXTEEN];
    endproperty
    a_sixteen: assert property (p_sixteen) else $error("sixteen zero flag missed"); // R3

    property p_codeword;
        @(posedge ref_clk) disable iff (rst)
        (hdb3_word && !line_standard_select) |=> rx_info_one_r[RI_CODEWORD];
    endproperty
    a_codeword: assert property (p_codeword) else $error("codeword flag missed"); // R4

    property p_carrier_clr;
        @(posedge ref_clk) disable iff (rst)
        ($fell(carrier_loss) && !rd_rxinfo_done && !setup) |=> rx_info_one_r[RI_CARR_CLR][*2];
    endproperty
    a_carrier_clr: assert property (p_carrier_clr) else $error("carrier clear flag not held"); // R5

    property p_ones_end;
        @(posedge ref_clk) disable iff (rst)
        $fell(unframed_ones_rx) |=> rx_info_one_r[RI_ONES_END];
    endproperty
    a_ones_end: assert property (p_ones_end) else $error("ones end flag missed"); // R6

    property p_jitter;
        @(posedge ref_clk) disable iff (rst)
        (jitter_fifo_margin <= JIT_MARGIN) |=> rx_info_one_r[RI_JIT_LIM];
    endproperty
    a_jitter: assert property (p_jitter) else $error("jitter flag missed"); // R7

    property p_unassigned;
        @(posedge ref_clk) disable iff (rst)
        done |-> (rx_info_one_r[1:0] == 2'b00);
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned bits set"); // R8

    property p_summary;
        @(posedge ref_clk) disable iff (rst)
        (setup && hit(apb_req.paddr, IDX_SUMMARY) && !apb_req.pwrite) |=> (prdata[0] == $past(irq_r));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong"); // R9

    property p_txclk;
        @(posedge ref_clk) disable iff (rst)
        $rose(tx_clock_lost) |-> ($past(txclk_cnt_r) == TXCLK_LIMIT);
    endproperty
    a_txclk: assert property (p_txclk) else $error("clock loss timing wrong"); // R10

    property p_irq;
        @(posedge ref_clk) disable iff (rst)
        (status_view & irq_mask_reg_r) == 8'h00 ##1 (status_view & irq_mask_reg_r) == 8'h00
            |-> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enabled status"); // R11

    c_read_clear: cover property (@(posedge ref_clk) disable iff (rst)
        rd_rxinfo_done && rd_taken_r != 8'h00);
    c_codeword_b8zs: cover property (@(posedge ref_clk) disable iff (rst)
        b8zs_word && line_standard_select);
    c_irq_rise: cover property (@(posedge ref_clk) disable iff (rst) $rose(irq));
endmodule

/* File: bench/lam_line_src.sv */
// behavioural receive line source feeding bipolar symbols to one channel
module lam_line_src (
    input wire logic ref_clk,
    output logic rx_bit_valid,
    output logic rx_pos,
    output logic rx_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pol = 1'b0;
    initial begin
        rx_bit_valid = 1'b0;
        rx_pos = 1'b0;
        rx_neg = 1'b0;
    end
    // a violation repeats the last mark polarity, a plain mark alternates
    task automatic sym(input logic m, input logic v);
        @(posedge ref_clk);
        if (m && !v) begin
            pol = ~pol;
        end
        rx_bit_valid <= 1'b1;
        rx_pos <= m & pol;
        rx_neg <= m & ~pol;
        @(posedge ref_clk);
        // line content is meaningless between strobes, so show the inverse
        rx_bit_valid <= 1'b0;
        rx_pos <= ~(m & pol);
        rx_neg <= ~(m & ~pol);
    endtask
    task automatic zeros(input int n);
        repeat (n) sym(1'b0, 1'b0);
    endtask
endmodule

/* File: bench/liu_alarm_mask_and_rx_info_test.sv */
// self-checking bench for the channel mask and receive info registers
module liu_alarm_mask_and_rx_info_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lam_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    lam_apb_req_t req = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rbv, rp, rn, lost, irq, er;
    logic sel = 1'b0;
    logic txc = 1'b0;
    logic txrun = 1'b1;
    logic [7:0] st = '0;
    logic [7:0] jit = 8'hFF;
    logic [3:1] oci = '0;
    int err_count = 0;
    int num_checks = 0;
    int zn[6] = '{3, 4, 7, 8, 15, 16};
    logic zs[6] = '{0, 0, 1, 1, 0, 0};
    logic [31:0] ze[6] = '{32'h0, 32'h80, 32'h0, 32'h80, 32'h80, 32'hC0};

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (txrun) txc <= ~txc;
    end

    lam_channel_regs DUT (.ref_clk(ref_clk), .rst(rst), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_bit_valid(rbv), .rx_pos(rp), .rx_neg(rn),
        .line_standard_select(sel), .loop_up_code_seen(st[7]), .loop_down_code_seen(st[6]),
        .unframed_ones_rx(st[4]), .carrier_loss(st[3]), .tx_current_limit_hit(st[2]),
        .tx_open_circuit(st[1]), .prbs_pattern_found(st[0]), .tx_clock_in(txc),
        .jitter_fifo_margin(jit), .other_chan_irq(oci), .tx_clock_lost(lost), .irq(irq));
    lam_line_src SRC (.ref_clk(ref_clk), .rx_bit_valid(rbv), .rx_pos(rp), .rx_neg(rn));

    function automatic logic [7:0] ba(input logic [7:0] i);
        return {i[5:0], 2'b00};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // holds the request until pready is seen, then releases at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        er = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
        input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // irq follows a mask or status change one cycle late
    task automatic ichk(input logic e);
        tick(2);
        @(negedge ref_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        chk("watchdog", 32'h0, 32'h1);
        results();
    end

    initial begin
        tick(5);
        rst <= 1'b0;
        rchk(ba(IDX_MASK), 32'h0, '1, "mask");
        rchk(ba(IDX_RXINFO), 32'h0, 32'hFC, "rx_info");
        ichk(1'b0);
        wr(ba(IDX_MASK), 32'hA5);
        rchk(ba(IDX_MASK), 32'hA5, '1, "mask");
        xfer(1'b0, 8'hFC, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        wr(8'hFC, 32'h0);
        rchk(ba(IDX_MASK), 32'hA5, '1, "mask_kept");
        wr(ba(IDX_MASK), 32'h0);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            sel <= zs[i];
            SRC.sym(1'b1, 1'b0);
            SRC.zeros(zn[i]);
            SRC.sym(1'b1, 1'b0);
            rchk(ba(IDX_RXINFO), ze[i], 32'hC0, "zero_run");
            rchk(ba(IDX_RXINFO), 32'h0, 32'hC0, "zero_run_clear");
        end
        $display("test zero runs done");
        // an hdb3 word under select 1 must not count
        sel <= 1'b1;
        SRC.sym(1'b1, 1'b0);
        SRC.zeros(3);
        SRC.sym(1'b1, 1'b1);
        SRC.sym(1'b1, 1'b0);
        SRC.sym(1'b1, 1'b0);
        rchk(ba(IDX_RXINFO), 32'h0, 32'hE0, "codeword_none");
        sel <= 1'b0;
        SRC.sym(1'b1, 1'b0);
        SRC.zeros(3);
        SRC.sym(1'b1, 1'b1);
        rchk(ba(IDX_RXINFO), 32'h20, 32'hE0, "codeword_sel0");
        sel <= 1'b1;
        SRC.sym(1'b1, 1'b0);
        SRC.zeros(3);
        SRC.sym(1'b1, 1'b1);
        SRC.sym(1'b1, 1'b0);
        SRC.sym(1'b0, 1'b0);
        SRC.sym(1'b1, 1'b1);
        SRC.sym(1'b1, 1'b0);
        rchk(ba(IDX_RXINFO), 32'h20, 32'hE0, "codeword_sel1");
        rchk(ba(IDX_RXINFO), 32'h0, 32'hE0, "codeword_clear");
        $display("test codewords done");
        st[3] <= 1'b1;
        st[4] <= 1'b1;
        tick(2);
        st[3] <= 1'b0;
        st[4] <= 1'b0;
        tick(20);
        rchk(ba(IDX_RXINFO), 32'h18, 32'hFC, "alarm_clear");
        rchk(ba(IDX_RXINFO), 32'h0, 32'hFC, "alarm_clear_read");
        jit <= 8'h05;
        tick(3);
        jit <= 8'hFF;
        rchk(ba(IDX_RXINFO), 32'h0, 32'hFC, "jitter_far");
        jit <= JIT_MARGIN;
        tick(1);
        jit <= 8'hFF;
        tick(20);
        rchk(ba(IDX_RXINFO), 32'h04, 32'hFC, "jitter_near");
        rchk(ba(IDX_RXINFO), 32'h0, 32'hFC, "jitter_read");
        wr(ba(IDX_STATUS), 32'hD8);
        $display("test events done");
        for (int i = 0; i < 8; i++) begin
            if (i == 5) continue;
            st[i] <= 1'b1;
            wr(ba(IDX_MASK), 32'h1 << i);
            ichk(1'b1);
            rchk(ba(IDX_STATUS), 32'h1 << i, '1, "status");
            rchk(ba(IDX_SUMMARY), 32'h1, 32'hF, "summary");
            wr(ba(IDX_MASK), ~(32'h1 << i) & 32'hFF);
            ichk(1'b0);
            st[i] <= 1'b0;
            wr(ba(IDX_STATUS), 32'h1 << i);
            rchk(ba(IDX_STATUS), 32'h0, '1, "status_clear");
        end
        xfer(1'b0, ba(IDX_RXINFO), 32'h0);
        oci <= 3'b101;
        tick(2);
        rchk(ba(IDX_SUMMARY), 32'h0A, 32'hF, "summary_others");
        $display("test interrupts done");
        // idle window kept inside the allowed 3 to 7 us span
        wr(ba(IDX_MASK), 32'h20);
        txrun <= 1'b0;
        tick(950);
        @(negedge ref_clk);
        chk("tx_clock_lost", 32'h0, {31'h0, lost});
        tick(100);
        @(negedge ref_clk);
        chk("tx_clock_lost", 32'h1, {31'h0, lost});
        ichk(1'b1);
        rchk(ba(IDX_STATUS), 32'h20, '1, "status_txclk");
        txrun <= 1'b1;
        // restarted clock needs two edges before the watchdog sees a transition
        tick(2);
        ichk(1'b0);
        $display("test transmit clock done");
        results();
    end
endmodule
